// ---- core/synth_enable_strobe_regs.sv ----
// Serial register port with the strobe and enable/reset registers of the synthesizer
`timescale 1ns/1ps
module synth_enable_strobe_regs
   import synth_regs_pkg::*;
#(
   // Arbitrary identification value, not a real part code
   parameter logic [DATA_W-1:0] CHIP_ID = 24'h00a5c3
) (
   input  wire logic mclk,
   input  wire logic reset_n,
   input  wire logic sen,
   input  wire logic sclk,
   input  wire logic sdi,
   output logic      sdo,
   output logic      sdo_oe,
   input  wire logic sine_select,
   input  wire logic csp_allow,
   input  wire logic integer_mode,
   output logic      config_reset_pulse,
   output logic      digital_reset_pulse,
   output logic      temp_measure_pulse,
   output logic      bias_on,
   output logic      vco_buffer_on,
   output logic      refdiv_run,
   output logic      xref_mux_gate,
   output logic      refdiv_clk_gate,
   output logic      sq_xtal_gate,
   output logic      sin_xtal_gate,
   output logic      square_refbuffer_on,
   output logic      sine_refbuffer_on,
   output logic      modclk_from_vco,
   output logic      prescaler_on,
   output logic      lock_gate_on,
   output logic      chargepump_on,
   output logic      chargepump_hiz,
   output logic      modulator_run,
   output logic      lockdet_run,
   output logic      cycle_slip_prevention
);

   logic [2:0]        pins;
   logic [2:0]        s1_q, s2_q, s3_q;
   logic [2:0]        pin_q, pin_d, prev_q;
   logic              sclk_rise;
   link_state_e       state_q, state_d;
   logic [CNT_W-1:0]  cnt_q, cnt_d;
   logic [DATA_W-1:0] shift_q, shift_d;
   logic [DATA_W-1:0] out_q, out_d;
   logic [ADDR_W-1:0] addr_q, addr_d;
   logic              rd_q, rd_d;
   logic              oe_q, oe_d;
   logic              wr;
   logic [DATA_W-1:0] wr_data;
   logic [EN_W-1:0]   enable_q, enable_d;
   logic [STB_W-1:0]  stb_q, stb_d;
   logic [EN_W-1:0]   ctrl_q, ctrl_d;

   assign pins = {sdi, sclk, sen};

   // Pin filter: a level counts once the second and third stages agree
   generate
      for (genvar i = 0; i < 3; i++) begin : g_pin
         always_comb begin
            pin_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : pin_q[i];
         end
      end
   endgenerate

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         s1_q   <= 3'h0;
         s2_q   <= 3'h0;
         s3_q   <= 3'h0;
         pin_q  <= 3'h0;
         prev_q <= 3'h0;
      end else begin
         s1_q   <= pins;
         s2_q   <= s1_q;
         s3_q   <= s2_q;
         pin_q  <= pin_d;
         prev_q <= pin_q;
      end
   end

   assign sclk_rise = pin_q[PIN_SCLK] & ~prev_q[PIN_SCLK];

   function automatic logic [DATA_W-1:0] read_word(input logic [ADDR_W-1:0] a,
                                                   input logic [EN_W-1:0] en);
      logic [DATA_W-1:0] w;
      w = '0;
      // Strobe bits are write-only; this address reads the identifier
      if (a == STROBE_ADDR) begin
         w = CHIP_ID;
      end else if (a == ENABLE_ADDR) begin
         w = {{(DATA_W-EN_W){1'b0}}, en};
      end
      return w;
   endfunction : read_word

   // Serial frame: read flag, six address bits, 24 data bits, all MSB first
   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q;
      shift_d = shift_q;
      out_d   = out_q;
      addr_d  = addr_q;
      rd_d    = rd_q;
      oe_d    = oe_q;
      wr      = 1'b0;
      // The 32nd rise only closes the frame; its data bit is not part of the word
      wr_data = shift_q;
      case (state_q)
         ST_IDLE: begin
            oe_d = 1'b0;
            if (pin_q[PIN_SEN] && sclk_rise) begin
               rd_d    = pin_q[PIN_SDI];
               cnt_d   = 5'h01;
               state_d = ST_SHIFT;
            end
         end
         ST_SHIFT: begin
            if (!pin_q[PIN_SEN]) begin
               // Frame cut short: nothing is committed
               oe_d    = 1'b0;
               state_d = ST_IDLE;
            end else if (sclk_rise) begin
               shift_d = {shift_q[DATA_W-2:0], pin_q[PIN_SDI]};
               cnt_d   = cnt_q + 5'h01;
               if (cnt_q == ADDR_LAST_CNT) begin
                  addr_d = {shift_q[ADDR_W-2:0], pin_q[PIN_SDI]};
               end
               if (rd_q && cnt_q == DATA_FIRST_CNT) begin
                  out_d = read_word(addr_q, enable_q);
                  oe_d  = 1'b1;
               end else if (rd_q && cnt_q > DATA_FIRST_CNT) begin
                  out_d = {out_q[DATA_W-2:0], 1'b0};
               end
               if (cnt_q == FRAME_LAST_CNT) begin
                  wr      = ~rd_q;
                  state_d = ST_WAIT;
               end
            end
         end
         ST_WAIT: begin
            if (!pin_q[PIN_SEN]) begin
               oe_d    = 1'b0;
               state_d = ST_IDLE;
            end
         end
         default: begin
            oe_d    = 1'b0;
            state_d = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         state_q <= ST_IDLE;
         cnt_q   <= '0;
         shift_q <= '0;
         out_q   <= '0;
         addr_q  <= '0;
         rd_q    <= 1'b0;
         oe_q    <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         shift_q <= shift_d;
         out_q   <= out_d;
         addr_q  <= addr_d;
         rd_q    <= rd_d;
         oe_q    <= oe_d;
      end
   end

   assign sdo    = out_q[DATA_W-1];
   assign sdo_oe = oe_q;

   // Register file
   always_comb begin
      enable_d = enable_q;
      stb_d    = '0;
      if (stb_q[STB_CFG]) begin
         enable_d = ENABLE_RESET;
      end
      if (wr && addr_q == ENABLE_ADDR) begin
         enable_d = wr_data[EN_W-1:0];
      end
      if (wr && addr_q == STROBE_ADDR) begin
         stb_d = wr_data[STB_W-1:0];
      end
   end

   // Analog controls; bias off overrides every other enable
   always_comb begin
      ctrl_d            = enable_q & {EN_W{enable_q[EN_BIAS]}};
      ctrl_d[EN_SQBUF]  = enable_q[EN_SQBUF] & ~sine_select & enable_q[EN_BIAS];
      ctrl_d[EN_SINBUF] = enable_q[EN_SINBUF] & sine_select & enable_q[EN_BIAS];
      ctrl_d[EN_DSM]    = enable_q[EN_DSM] & ~integer_mode & enable_q[EN_BIAS];
      ctrl_d[EN_CSP]    = enable_q[EN_CSP] & csp_allow & enable_q[EN_BIAS];
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         enable_q <= ENABLE_RESET;
         stb_q    <= '0;
         // Input-gated enables stay off until the gating inputs have been sampled
         ctrl_q   <= ENABLE_RESET & ~((EN_W'(1) << EN_SQBUF) | (EN_W'(1) << EN_SINBUF)
                                      | (EN_W'(1) << EN_DSM) | (EN_W'(1) << EN_CSP));
      end else begin
         enable_q <= enable_d;
         stb_q    <= stb_d;
         ctrl_q   <= ctrl_d;
      end
   end

   assign config_reset_pulse    = stb_q[STB_CFG];
   assign digital_reset_pulse   = stb_q[STB_DIG];
   assign temp_measure_pulse    = stb_q[STB_TEMP];
   assign bias_on               = ctrl_q[EN_BIAS];
   assign vco_buffer_on         = ctrl_q[EN_VCOBUF];
   assign refdiv_run            = ctrl_q[EN_REFDIV];
   assign xref_mux_gate         = ctrl_q[EN_XMUX];
   assign refdiv_clk_gate       = ctrl_q[EN_DIVDIG];
   assign sq_xtal_gate          = ctrl_q[EN_SQDIG];
   assign sin_xtal_gate         = ctrl_q[EN_SINDIG];
   assign square_refbuffer_on   = ctrl_q[EN_SQBUF];
   assign sine_refbuffer_on     = ctrl_q[EN_SINBUF];
   assign modclk_from_vco       = ctrl_q[EN_VCOCLK];
   assign prescaler_on          = ctrl_q[EN_PRESC];
   // lock gates held in reset when low
   assign lock_gate_on          = ctrl_q[EN_LOCKG];
   // charge pump drive or high impedance
   assign chargepump_on         = ctrl_q[EN_CP];
   assign chargepump_hiz        = ~ctrl_q[EN_CP];
   assign modulator_run         = ctrl_q[EN_DSM];
   assign lockdet_run           = ctrl_q[EN_LKD];
   assign cycle_slip_prevention = ctrl_q[EN_CSP];

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);

   sequence strobe_write_s(int b);
      wr && addr_q == STROBE_ADDR && wr_data[b];
   endsequence

   sequence enable_write_s;
      wr && addr_q == ENABLE_ADDR;
   endsequence

   strobe_single_a : assert property (config_reset_pulse |=> !config_reset_pulse)
      else $error("configuration strobe longer than one cycle");
   dig_reset_a : assert property (strobe_write_s(STB_DIG) |=> digital_reset_pulse)
      else $error("digital reset strobe missing");
   temp_start_a : assert property (strobe_write_s(STB_TEMP) |=> temp_measure_pulse)
      else $error("temperature strobe missing");
   cfg_default_a : assert property (config_reset_pulse |=> enable_q == ENABLE_RESET)
      else $error("enable register not restored");
   enable_store_a : assert property (enable_write_s |=> enable_q == $past(wr_data[EN_W-1:0]))
      else $error("enable write not stored");
   bias_off_a : assert property (!enable_q[EN_BIAS] |=> !prescaler_on && !chargepump_on)
      else $error("blocks on while bias off");
   sq_buffer_a : assert property (square_refbuffer_on |-> !$past(sine_select))
      else $error("square buffer on with sine select");
   sin_buffer_a : assert property (sine_refbuffer_on |-> $past(sine_select))
      else $error("sine buffer on without sine select");
   cp_hiz_a : assert property (!enable_q[EN_CP] |=> chargepump_hiz && !chargepump_on)
      else $error("charge pump driven while disabled");
   csp_gate_a : assert property (cycle_slip_prevention |->
      $past(enable_q[EN_CSP] && csp_allow))
      else $error("cycle slip prevention without both enables");
   dsm_gate_a : assert property (modulator_run |-> !$past(integer_mode))
      else $error("modulator running in integer mode");
   sdo_window_a : assert property ($rose(sdo_oe) |-> rd_q && state_q == ST_SHIFT)
      else $error("serial output driven outside a read");
   refdiv_hold_a : assert property (!enable_q[EN_REFDIV] |=> !refdiv_run)
      else $error("reference divider released while disabled");
   lock_gate_a : assert property (!enable_q[EN_LOCKG] |=> !lock_gate_on)
      else $error("lock gates enabled while held in reset");
   lockdet_hold_a : assert property (!enable_q[EN_LKD] |=> !lockdet_run)
      else $error("lock detector running while held in reset");
   temp_single_a : assert property (temp_measure_pulse |=> !temp_measure_pulse)
      else $error("temperature strobe longer than one cycle");

endmodule : synth_enable_strobe_regs

// ---- include/synth_regs_pkg.sv ----
// Constants and types for the synthesizer enable and strobe register block
// What this block does
// - Strobe bit 1 written one pulses soft reset of digital logic outside registers.
// - Strobe bit 3 written one starts one temperature measurement.
// - Enable bit 1 is master bias; zero disables whole synthesizer; resets one.
// - Enable bit 2 cleared holds reference divider in reset; resets zero.
// - Enable bit 3 gates muxed crystal reference into digital logic.
// - Enable bit 4 gates divided reference clock to digital; resets one.
// - Enable bit 5 gates square crystal clock to digital; resets zero.
// - Enable bit 6 gates sine crystal clock to digital; resets zero.
// - Enable bit 7 runs square reference buffer only while sine select is zero.
// - Enable bit 8 runs sine reference buffer only while sine select is one.
// - Enable bit 9 one picks divided oscillator clock, zero divided reference.
// - Enable bit 10 turns prescaler bias on; resets one.
// - Enable bit 11 is active-low reset of the lock gates; the lock detector runs on bit 14.
// - Enable bit 12 enables charge pump; cleared means high impedance output.
// - Enable bit 13 one runs fractional modulator unless integer mode.
// - Enable bit 14 one lets the lock detect circuit operate.
// - Enable bit 15 enables cycle slip prevention only with its other enable.
// - Strobe bit 0 written one restores configuration registers to defaults.
package synth_regs_pkg;
   localparam int unsigned ADDR_W     = 6;
   localparam int unsigned DATA_W     = 24;
   localparam int unsigned EN_W       = 16;
   localparam int unsigned STB_W      = 4;
   localparam int unsigned CNT_W      = 5;
   localparam int unsigned PIN_SEN    = 0;
   localparam int unsigned PIN_SCLK   = 1;
   localparam int unsigned PIN_SDI    = 2;
   localparam logic [ADDR_W-1:0] STROBE_ADDR = 6'h00;
   localparam logic [ADDR_W-1:0] ENABLE_ADDR = 6'h01;
   localparam logic [EN_W-1:0]   ENABLE_RESET = 16'hfe9b;
   localparam logic [CNT_W-1:0]  ADDR_LAST_CNT = 5'h06;
   localparam logic [CNT_W-1:0]  DATA_FIRST_CNT = 5'h07;
   localparam logic [CNT_W-1:0]  FRAME_LAST_CNT = 5'h1f;
   localparam int unsigned STB_CFG    = 0;
   localparam int unsigned STB_DIG    = 1;
   localparam int unsigned STB_TEMP   = 3;
   localparam int unsigned EN_VCOBUF  = 0;
   localparam int unsigned EN_BIAS    = 1;
   localparam int unsigned EN_REFDIV  = 2;
   localparam int unsigned EN_XMUX    = 3;
   localparam int unsigned EN_DIVDIG  = 4;
   localparam int unsigned EN_SQDIG   = 5;
   localparam int unsigned EN_SINDIG  = 6;
   localparam int unsigned EN_SQBUF   = 7;
   localparam int unsigned EN_SINBUF  = 8;
   localparam int unsigned EN_VCOCLK  = 9;
   localparam int unsigned EN_PRESC   = 10;
   localparam int unsigned EN_LOCKG   = 11;
   localparam int unsigned EN_CP      = 12;
   localparam int unsigned EN_DSM     = 13;
   localparam int unsigned EN_LKD     = 14;
   localparam int unsigned EN_CSP     = 15;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_SHIFT = 3'b010,
      ST_WAIT  = 3'b100
   } link_state_e;
endpackage : synth_regs_pkg

// ---- testbench/serial_host.sv ----
// Behavioural host that frames accesses on the serial register port
`timescale 1ns/1ps
module serial_host (
   input  wire logic mclk,
   output logic      sen,
   output logic      sclk,
   output logic      sdi,
   input  wire logic sdo
);
   initial begin
      sen  = 1'b0;
      sclk = 1'b0;
      sdi  = 1'b1;
   end
   // Phases of 8 mclk leave room for the pin filter; nbits below 32 aborts
   task automatic frame(input logic rd, input logic [5:0] addr, input logic [23:0] wdata,
                        input int nbits, output logic [23:0] rdata);
      logic [31:0] bits;
      bits  = {rd, addr, wdata, 1'b0};
      rdata = 24'h000000;
      for (int i = 0; i < nbits; i++) begin
         @(negedge mclk);
         sen = 1'b1;
         sdi = bits[31-i];
         repeat (8) @(negedge mclk);
         sclk = 1'b1;
         repeat (8) @(negedge mclk);
         if (rd && i >= 7 && i <= 30) begin
            rdata = {rdata[22:0], sdo};
         end
         sclk = 1'b0;
      end
      repeat (8) @(negedge mclk);
      sen = 1'b0;
      // Released data line shows the inverse, not a stale bit
      sdi = ~sdi;
      repeat (8) @(negedge mclk);
   endtask : frame
endmodule : serial_host

// ---- testbench/synth_enable_strobe_regs_test.sv ----
// Self-checking bench for the enable and strobe register block
`timescale 1ns/1ps
module synth_enable_strobe_regs_test;
   import synth_regs_pkg::*;
   // Arbitrary identification value
   localparam logic [23:0] ID_VAL = 24'h3c5a96;
   logic mclk, reset_n, sen, sclk, sdi, sdo, sdo_oe, ss, cs, im;
   logic cfg_p, dig_p, temp_p, bias, vcob, rdr, xmux, rclk, sqx, sinx, sqb, sinb;
   logic modv, presc, lockg, cp, hiz, modr, lkd, slip;
   logic [16:0] outs;
   logic [7:0]  n_cfg = 8'h00, n_dig = 8'h00, n_temp = 8'h00;
   logic [15:0] n_oe = 16'h0000;
   logic [23:0] rdv;
   int          fail_count, samples_checked;
   int          cycles = 0;
   assign outs = {bias, vcob, rdr, xmux, rclk, sqx, sinx, sqb, sinb, modv, presc, lockg,
                  cp, hiz, modr, lkd, slip};
   synth_enable_strobe_regs #(.CHIP_ID(ID_VAL)) i_synth_enable_strobe_regs (
      .mclk(mclk), .reset_n(reset_n), .sen(sen), .sclk(sclk), .sdi(sdi), .sdo(sdo),
      .sdo_oe(sdo_oe), .sine_select(ss), .csp_allow(cs), .integer_mode(im),
      .config_reset_pulse(cfg_p), .digital_reset_pulse(dig_p), .temp_measure_pulse(temp_p),
      .bias_on(bias), .vco_buffer_on(vcob), .refdiv_run(rdr), .xref_mux_gate(xmux),
      .refdiv_clk_gate(rclk), .sq_xtal_gate(sqx), .sin_xtal_gate(sinx),
      .square_refbuffer_on(sqb), .sine_refbuffer_on(sinb), .modclk_from_vco(modv),
      .prescaler_on(presc), .lock_gate_on(lockg), .chargepump_on(cp),
      .chargepump_hiz(hiz), .modulator_run(modr), .lockdet_run(lkd),
      .cycle_slip_prevention(slip));
   serial_host i_serial_host (.mclk(mclk), .sen(sen), .sclk(sclk), .sdi(sdi), .sdo(sdo));
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   // Counting high cycles proves each strobe is exactly one cycle wide
   always @(posedge mclk) begin
      n_cfg  <= n_cfg + 8'(cfg_p === 1'b1);
      n_dig  <= n_dig + 8'(dig_p === 1'b1);
      n_temp <= n_temp + 8'(temp_p === 1'b1);
      n_oe   <= n_oe + 16'(sdo_oe === 1'b1);
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         fail_count++;
         wrap_up();
      end
   end
   function automatic logic [16:0] expect_outs(logic [15:0] e, logic s, logic c, logic m);
      logic [15:0] g;
      g = e[1] ? e : 16'h0000;
      return {g[1], g[0], g[2], g[3], g[4], g[5], g[6], g[7] & ~s, g[8] & s, g[9], g[10],
              g[11], g[12], ~g[12], g[13] & ~m, g[14], g[15] & c};
   endfunction : expect_outs
   task automatic check_data(input logic [23:0] got, input logic [23:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check_data
   task automatic check_outs(input logic [15:0] e);
      samples_checked++;
      if (outs !== expect_outs(e, ss, cs, im)) begin
         fail_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, outs, expect_outs(e, ss, cs, im));
      end
   endtask : check_outs
   task automatic access(input logic rd, input logic [5:0] a, input logic [23:0] d, int n);
      i_serial_host.frame(rd, a, d, n, rdv);
      repeat (4) @(negedge mclk);
   endtask : access
   task automatic test_reset();
      logic [15:0] o0;
      check_outs(ENABLE_RESET);
      o0 = n_oe;
      access(1'b1, ENABLE_ADDR, 24'h000000, 32);
      check_data(rdv, {8'h00, ENABLE_RESET});
      // Output driver was on during the read and is off again once sen drops
      check_data({22'h0, sdo_oe, (n_oe != o0)}, 24'h000001);
      $display("test_reset done");
   endtask : test_reset
   task automatic test_fields();
      logic [15:0] pat [5] = '{16'h0002, 16'haaaa, 16'h5555, 16'h7ffd, 16'hffff};
      for (int i = 0; i < 5; i++) begin
         {ss, cs, im} = 3'(i + 3);
         access(1'b0, ENABLE_ADDR, {8'h00, pat[i]}, 32);
         check_outs(pat[i]);
         access(1'b1, ENABLE_ADDR, 24'h000000, 32);
         check_data(rdv, {8'h00, pat[i]});
      end
      for (int k = 0; k < 8; k++) begin
         {ss, cs, im} = 3'(k);
         repeat (3) @(negedge mclk);
         check_outs(16'hffff);
      end
      $display("test_fields done");
   endtask : test_fields
   // Pulse counts are taken as differences, so the counters keep a single driver
   task automatic strobe_case(input logic [23:0] d, input logic [23:0] exp);
      logic [7:0] c0, d0, t0;
      c0 = n_cfg;
      d0 = n_dig;
      t0 = n_temp;
      access(1'b0, STROBE_ADDR, d, 32);
      check_data({n_cfg - c0, n_dig - d0, n_temp - t0}, exp);
   endtask : strobe_case
   task automatic test_strobes();
      access(1'b0, ENABLE_ADDR, 24'h001236, 32);
      strobe_case(24'h000008, 24'h000001);
      strobe_case(24'h000002, 24'h000100);
      strobe_case(24'h000004, 24'h000000);
      access(1'b1, ENABLE_ADDR, 24'h000000, 32);
      check_data(rdv, 24'h001236);
      strobe_case(24'h000001, 24'h010000);
      access(1'b1, ENABLE_ADDR, 24'h000000, 32);
      check_data(rdv, {8'h00, ENABLE_RESET});
      access(1'b1, STROBE_ADDR, 24'h000000, 32);
      check_data(rdv, ID_VAL);
      $display("test_strobes done");
   endtask : test_strobes
   task automatic test_refuse();
      logic [15:0] o0;
      access(1'b0, ENABLE_ADDR, 24'h00aaaa, 32);
      access(1'b0, ENABLE_ADDR, 24'h000000, 20);
      o0 = n_oe;
      access(1'b0, 6'h05, 24'hffffff, 32);
      // A write frame never turns the output driver on
      check_data({22'h0, sdo_oe, (n_oe != o0)}, 24'h000000);
      access(1'b1, 6'h05, 24'h000000, 32);
      check_data(rdv, 24'h000000);
      access(1'b1, ENABLE_ADDR, 24'h000000, 32);
      check_data(rdv, 24'h00aaaa);
      check_outs(16'haaaa);
      $display("test_refuse done");
   endtask : test_refuse
   task automatic test_midreset();
      access(1'b0, ENABLE_ADDR, 24'h000002, 32);
      check_outs(16'h0002);
      reset_n = 1'b0;
      repeat (2) @(negedge mclk);
      reset_n = 1'b1;
      repeat (3) @(negedge mclk);
      check_outs(ENABLE_RESET);
      access(1'b1, ENABLE_ADDR, 24'h000000, 32);
      check_data(rdv, {8'h00, ENABLE_RESET});
      $display("test_midreset done");
   endtask : test_midreset
   task automatic wrap_up();
      $display("checks=%0d mismatches=%0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : wrap_up
   initial begin
      fail_count = 0;
      samples_checked = 0;
      reset_n = 1'b0;
      {ss, cs, im} = 3'b010;
      repeat (5) @(negedge mclk);
      reset_n = 1'b1;
      repeat (3) @(negedge mclk);
      test_reset();
      test_fields();
      test_strobes();
      test_refuse();
      test_midreset();
      wrap_up();
   end
endmodule : synth_enable_strobe_regs_test
